// ### sfsr_map.vh
// Function
// - While suspended, read, fast read, page and quad page program work everywhere except the erased sector or block.
// - After suspend, wait the latency, clear write enable latch, set suspended flag.
// - After latency, accept write enable, write disable, page and quad page program.
// - After latency, accept all listed array reads and set burst with wrap.
// - After latency, accept identification, unique ID, security and parameter table reads.
// - Status register reads are accepted at any time after suspend.
// - Reset enable and reset device are accepted at any time after suspend.
// - Suspended flag is status bit 15.
// - Suspended flag sets on suspend, clears on resume.
// - Resume acts only with suspended flag one and write in progress zero.
// - Accepted resume clears suspended flag at once and completes the erase.
// - Accepted resume raises write in progress within 200 ns.
// - Suspend instruction 75h interrupts sector, 32KB or 64KB block erase.
// - A write status register operation is never suspended.
// - Write in progress is one during erase and zero when it ends.
`ifndef SFSR_MAP_VH
`define SFSR_MAP_VH

// ****************************************
// Opcodes
// ****************************************
`define SFSR_OP_WREN    8'h06
`define SFSR_OP_WRDI    8'h04
`define SFSR_OP_WRSR    8'h01
`define SFSR_OP_RD      8'h03
`define SFSR_OP_FRD     8'h0b
`define SFSR_OP_DORD    8'h3b
`define SFSR_OP_QORD    8'h6b
`define SFSR_OP_DIORD   8'hbb
`define SFSR_OP_QIORD   8'heb
`define SFSR_OP_QWRD    8'he7
`define SFSR_OP_BURST   8'h77
`define SFSR_OP_MDID    8'h90
`define SFSR_OP_DMDID   8'h92
`define SFSR_OP_QMDID   8'h94
`define SFSR_OP_JEDID   8'h9f
`define SFSR_OP_UID     8'h4b
`define SFSR_OP_RELID   8'hab
`define SFSR_OP_SECRD   8'h48
`define SFSR_OP_SFDP    8'h5a
`define SFSR_OP_PP      8'h02
`define SFSR_OP_QPP     8'h32
`define SFSR_OP_SE      8'h20
`define SFSR_OP_BE32    8'h52
`define SFSR_OP_BE64    8'hd8
`define SFSR_OP_SUSP    8'h75
`define SFSR_OP_RESUME  8'h7a
`define SFSR_OP_RDSR1   8'h05
`define SFSR_OP_RDSR2   8'h35
`define SFSR_OP_RDSR3   8'h15
`define SFSR_OP_RSTEN   8'h66
`define SFSR_OP_RST     8'h99

// ****************************************
// Status fields and erase types
// ****************************************
`define SFSR_ST_WIP_BIT 0
`define SFSR_ST_WEL_BIT 1
`define SFSR_ST_SUS_BIT 15
`define SFSR_ET_4K      2'h0
`define SFSR_ET_32K     2'h1
`define SFSR_ET_64K     2'h2

// ****************************************
// Timing
// ****************************************
`define SFSR_CLK_NS         8
`define SFSR_SUSP_LAT_NS    20000
`define SFSR_SUSP_LAT_CYC   ((`SFSR_SUSP_LAT_NS + `SFSR_CLK_NS - 1) / `SFSR_CLK_NS)
`define SFSR_RESUME_MAX_NS  200
`define SFSR_RESUME_MAX_CYC (`SFSR_RESUME_MAX_NS / `SFSR_CLK_NS)
`define SFSR_ERASE_CYC      100000
`define SFSR_PROG_CYC       5000
`define SFSR_WRSR_CYC       5000

`endif

// ### sfsr_spi_rx.v
`timescale 1ns/1ns
// ****************************************
// Pin sampling and byte assembly
// ****************************************
module sfsr_spi_rx (
    // Clock and reset
    input  wire       clk_sys_i,
    input  wire       rst_n_i,
    // Pins
    input  wire       cs_n_i,
    input  wire       sclk_i,
    input  wire       si_i,
    // Byte stream
    output reg  [7:0] byte_o,
    output reg        byte_vld_o,
    output reg  [2:0] byte_cnt_o,
    output reg        frame_end_o,
    output reg        sclk_fall_o,
    output reg        active_o
);
    reg [2:0] sync1_reg;
    reg [2:0] sync2_reg;
    reg       sclk_d_reg;
    reg       cs_d_reg;
    reg [2:0] bit_reg;
    reg [7:0] sh_reg;

    // Two flip-flop synchronisers
    always @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            sync1_reg <= 3'h1;
            sync2_reg <= 3'h1;
        end else begin
            sync1_reg <= {si_i, sclk_i, cs_n_i};
            sync2_reg <= sync1_reg;
        end
    end

    // Edge detection and shifting
    always @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            sclk_d_reg  <= 1'b0;
            cs_d_reg    <= 1'b1;
            bit_reg     <= 3'h0;
            sh_reg      <= 8'h00;
            byte_o      <= 8'h00;
            byte_vld_o  <= 1'b0;
            byte_cnt_o  <= 3'h0;
            frame_end_o <= 1'b0;
            sclk_fall_o <= 1'b0;
            active_o    <= 1'b0;
        end else begin
            sclk_d_reg  <= sync2_reg[1];
            cs_d_reg    <= sync2_reg[0];
            byte_vld_o  <= 1'b0;
            frame_end_o <= sync2_reg[0] & ~cs_d_reg;
            sclk_fall_o <= ~sync2_reg[0] & sclk_d_reg & ~sync2_reg[1];
            active_o    <= ~sync2_reg[0];
            if (byte_vld_o && byte_cnt_o != 3'h7) begin
                byte_cnt_o <= byte_cnt_o + 3'h1;
            end
            if (sync2_reg[0]) begin
                bit_reg <= 3'h0;
                // Count holds through the frame end pulse
                if (cs_d_reg) begin
                    byte_cnt_o <= 3'h0;
                end
            end else if (sync2_reg[1] && !sclk_d_reg) begin
                sh_reg  <= {sh_reg[6:0], sync2_reg[2]};
                bit_reg <= bit_reg + 3'h1;
                if (bit_reg == 3'h7) begin
                    byte_o     <= {sh_reg[6:0], sync2_reg[2]};
                    byte_vld_o <= 1'b1;
                end
            end
        end
    end
endmodule // sfsr_spi_rx

// ### sfsr_top.v
`timescale 1ns/1ns
`include "sfsr_map.vh"
module sfsr_top #(
    parameter [31:0] ERASE_CYCLES    = `SFSR_ERASE_CYC,
    parameter [31:0] PROG_CYCLES     = `SFSR_PROG_CYC,
    parameter [31:0] WRSR_CYCLES     = `SFSR_WRSR_CYC,
    parameter [31:0] SUSP_LAT_CYCLES = `SFSR_SUSP_LAT_CYC
) (
    // Clock and reset
    input  wire        clk_sys_i,
    input  wire        reset_n_i,
    // Serial link
    input  wire        cs_n_i,
    input  wire        sclk_i,
    input  wire        si_i,
    output reg         so_o,
    output reg         so_oe_o,
    // Status
    output reg  [15:0] status_o,
    output reg         erase_suspended_flag_o,
    output reg         write_in_progress_flag_o,
    output reg         write_enable_latch_o,
    // Events
    output reg         cmd_accept_o,
    output reg         cmd_reject_o,
    output reg  [7:0]  cmd_code_o,
    output reg         region_blocked_o,
    output reg         erase_done_o
);
    localparam [2:0] ST_IDLE  = 3'h0;
    localparam [2:0] ST_BUSY  = 3'h1;
    localparam [2:0] ST_SLAT  = 3'h2;
    localparam [2:0] ST_SUSP  = 3'h3;
    localparam [2:0] ST_SPROG = 3'h4;
    localparam [1:0] K_ERASE  = 2'h0;
    localparam [1:0] K_PROG   = 2'h1;
    localparam [1:0] K_WRSR   = 2'h2;

    reg        rst_s1_reg;
    reg        rst_n_reg;
    wire [7:0] rx_byte;
    wire       rx_vld;
    wire [2:0] rx_cnt;
    wire       rx_end;
    wire       rx_fall;
    wire       rx_act;

    reg [2:0]  state_reg;
    reg [1:0]  kind_reg;
    reg [1:0]  etype_reg;
    reg [23:0] eaddr_reg;
    reg [23:0] addr_reg;
    reg [31:0] ecnt_reg;
    reg [31:0] pcnt_reg;
    reg [31:0] lcnt_reg;
    reg [7:0]  op_reg;
    reg        op_ok_reg;
    reg        rsten_reg;
    reg [7:0]  so_sh_reg;

    // ****************************************
    // Reset release
    // ****************************************
    always @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            rst_s1_reg <= 1'b0;
            rst_n_reg  <= 1'b0;
        end else begin
            rst_s1_reg <= 1'b1;
            rst_n_reg  <= rst_s1_reg;
        end
    end

    sfsr_spi_rx u_rx (
        .clk_sys_i   (clk_sys_i),
        .rst_n_i     (rst_n_reg),
        .cs_n_i      (cs_n_i),
        .sclk_i      (sclk_i),
        .si_i        (si_i),
        .byte_o      (rx_byte),
        .byte_vld_o  (rx_vld),
        .byte_cnt_o  (rx_cnt),
        .frame_end_o (rx_end),
        .sclk_fall_o (rx_fall),
        .active_o    (rx_act)
    );

    // ****************************************
    // Decoding
    // ****************************************
    function early_ok;
        input [7:0] op;
        begin
            early_ok = (op == `SFSR_OP_RDSR1) || (op == `SFSR_OP_RDSR2) || (op == `SFSR_OP_RDSR3) ||
                       (op == `SFSR_OP_RSTEN) || (op == `SFSR_OP_RST);
        end
    endfunction

    function addr_op;
        input [7:0] op;
        begin
            addr_op = (op == `SFSR_OP_RD) || (op == `SFSR_OP_FRD) || (op == `SFSR_OP_PP) || (op == `SFSR_OP_QPP);
        end
    endfunction

    function late_ok;
        input [7:0] op;
        begin
            case (op)
                `SFSR_OP_WREN, `SFSR_OP_WRDI, `SFSR_OP_PP, `SFSR_OP_QPP: late_ok = 1'b1;
                `SFSR_OP_RD, `SFSR_OP_FRD, `SFSR_OP_DORD, `SFSR_OP_QORD, `SFSR_OP_DIORD,
                `SFSR_OP_QIORD, `SFSR_OP_QWRD, `SFSR_OP_BURST: late_ok = 1'b1;
                `SFSR_OP_MDID, `SFSR_OP_DMDID, `SFSR_OP_QMDID, `SFSR_OP_JEDID, `SFSR_OP_UID,
                `SFSR_OP_RELID, `SFSR_OP_SECRD, `SFSR_OP_SFDP, `SFSR_OP_RESUME: late_ok = 1'b1;
                default: late_ok = early_ok(op);
            endcase
        end
    endfunction

    function in_region;
        input [23:0] a;
        input [23:0] e;
        input [1:0]  t;
        begin
            case (t)
                `SFSR_ET_4K:  in_region = (a[23:12] == e[23:12]);
                `SFSR_ET_32K: in_region = (a[23:15] == e[23:15]);
                default:      in_region = (a[23:16] == e[23:16]);
            endcase
        end
    endfunction

    reg       allow;
    reg [1:0] etype_new;
    always @* begin
        case (state_reg)
            ST_IDLE:  allow = (rx_byte != `SFSR_OP_RESUME);
            ST_SUSP:  allow = late_ok(rx_byte);
            ST_SLAT:  allow = early_ok(rx_byte);
            default:  allow = early_ok(rx_byte) || (rx_byte == `SFSR_OP_SUSP);
        endcase
        case (op_reg)
            `SFSR_OP_SE:   etype_new = `SFSR_ET_4K;
            `SFSR_OP_BE32: etype_new = `SFSR_ET_32K;
            default:       etype_new = `SFSR_ET_64K;
        endcase
    end

    // ****************************************
    // Sequencer
    // ****************************************
    always @(posedge clk_sys_i or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            state_reg                <= ST_IDLE;
            kind_reg                 <= K_ERASE;
            etype_reg                <= `SFSR_ET_4K;
            eaddr_reg                <= 24'h000000;
            addr_reg                 <= 24'h000000;
            ecnt_reg                 <= 32'h00000000;
            pcnt_reg                 <= 32'h00000000;
            lcnt_reg                 <= 32'h00000000;
            op_reg                   <= 8'h00;
            op_ok_reg                <= 1'b0;
            rsten_reg                <= 1'b0;
            so_sh_reg                <= 8'h00;
            so_o                     <= 1'b0;
            so_oe_o                  <= 1'b0;
            erase_suspended_flag_o   <= 1'b0;
            write_in_progress_flag_o <= 1'b0;
            write_enable_latch_o     <= 1'b0;
            cmd_accept_o             <= 1'b0;
            cmd_reject_o             <= 1'b0;
            cmd_code_o               <= 8'h00;
            region_blocked_o         <= 1'b0;
            erase_done_o             <= 1'b0;
        end else begin
            cmd_accept_o     <= 1'b0;
            cmd_reject_o     <= 1'b0;
            region_blocked_o <= 1'b0;
            erase_done_o     <= 1'b0;
            if (rx_fall && so_oe_o) begin
                so_o      <= so_sh_reg[7];
                so_sh_reg <= {so_sh_reg[6:0], so_sh_reg[7]};
            end
            if (rx_vld && rx_cnt == 3'h0) begin
                op_reg       <= rx_byte;
                op_ok_reg    <= allow;
                cmd_code_o   <= rx_byte;
                cmd_accept_o <= allow;
                cmd_reject_o <= ~allow;
                if (allow && rx_byte == `SFSR_OP_RDSR1) begin
                    so_sh_reg <= status_o[7:0];
                    so_oe_o   <= 1'b1;
                end else if (allow && rx_byte == `SFSR_OP_RDSR2) begin
                    so_sh_reg <= status_o[15:8];
                    so_oe_o   <= 1'b1;
                end else if (allow && rx_byte == `SFSR_OP_RDSR3) begin
                    so_sh_reg <= 8'h00;
                    so_oe_o   <= 1'b1;
                end
            end else if (rx_vld && rx_cnt < 3'h4) begin
                addr_reg <= {addr_reg[15:0], rx_byte};
                if (rx_cnt == 3'h3 && op_ok_reg && addr_op(op_reg) && state_reg == ST_SUSP &&
                    in_region({addr_reg[15:0], rx_byte}, eaddr_reg, etype_reg)) begin
                    op_ok_reg        <= 1'b0;
                    region_blocked_o <= 1'b1;
                end
            end
            if (rx_end) begin
                so_oe_o   <= 1'b0;
                op_ok_reg <= 1'b0;
                rsten_reg <= op_ok_reg && (op_reg == `SFSR_OP_RSTEN);
            end
            if (rx_end && op_ok_reg) begin
                case (op_reg)
                    `SFSR_OP_WREN: write_enable_latch_o <= 1'b1;
                    `SFSR_OP_WRDI: write_enable_latch_o <= 1'b0;
                    `SFSR_OP_SE, `SFSR_OP_BE32, `SFSR_OP_BE64: begin
                        if (state_reg == ST_IDLE && write_enable_latch_o && rx_cnt == 3'h4) begin
                            state_reg                <= ST_BUSY;
                            kind_reg                 <= K_ERASE;
                            etype_reg                <= etype_new;
                            eaddr_reg                <= addr_reg;
                            ecnt_reg                 <= ERASE_CYCLES;
                            write_in_progress_flag_o <= 1'b1;
                        end
                    end
                    `SFSR_OP_WRSR: begin
                        if (state_reg == ST_IDLE && write_enable_latch_o) begin
                            state_reg                <= ST_BUSY;
                            kind_reg                 <= K_WRSR;
                            pcnt_reg                 <= WRSR_CYCLES;
                            write_in_progress_flag_o <= 1'b1;
                        end
                    end
                    `SFSR_OP_PP, `SFSR_OP_QPP: begin
                        if (write_enable_latch_o && rx_cnt > 3'h3 &&
                            (state_reg == ST_IDLE || state_reg == ST_SUSP)) begin
                            state_reg                <= (state_reg == ST_IDLE) ? ST_BUSY : ST_SPROG;
                            kind_reg                 <= K_PROG;
                            pcnt_reg                 <= PROG_CYCLES;
                            write_in_progress_flag_o <= 1'b1;
                        end
                    end
                    `SFSR_OP_SUSP: begin
                        if (state_reg == ST_BUSY && kind_reg == K_ERASE) begin
                            state_reg <= ST_SLAT;
                            lcnt_reg  <= SUSP_LAT_CYCLES;
                        end
                    end
                    `SFSR_OP_RESUME: begin
                        if (erase_suspended_flag_o && !write_in_progress_flag_o) begin
                            state_reg                <= ST_BUSY;
                            kind_reg                 <= K_ERASE;
                            erase_suspended_flag_o   <= 1'b0;
                            write_in_progress_flag_o <= 1'b1;
                        end
                    end
                    `SFSR_OP_RST: begin
                        if (rsten_reg) begin
                            state_reg                <= ST_IDLE;
                            erase_suspended_flag_o   <= 1'b0;
                            write_in_progress_flag_o <= 1'b0;
                            write_enable_latch_o     <= 1'b0;
                        end
                    end
                    default: ;
                endcase
            end else begin
                case (state_reg)
                    ST_BUSY: begin
                        if (kind_reg == K_ERASE) begin
                            if (ecnt_reg > 32'h00000001) begin
                                ecnt_reg <= ecnt_reg - 32'h00000001;
                            end else begin
                                state_reg                <= ST_IDLE;
                                write_in_progress_flag_o <= 1'b0;
                                write_enable_latch_o     <= 1'b0;
                                erase_done_o             <= 1'b1;
                            end
                        end else if (pcnt_reg > 32'h00000001) begin
                            pcnt_reg <= pcnt_reg - 32'h00000001;
                        end else begin
                            state_reg                <= ST_IDLE;
                            write_in_progress_flag_o <= 1'b0;
                            write_enable_latch_o     <= 1'b0;
                        end
                    end
                    ST_SLAT: begin
                        if (lcnt_reg > 32'h00000001) begin
                            lcnt_reg <= lcnt_reg - 32'h00000001;
                        end else begin
                            state_reg                <= ST_SUSP;
                            write_enable_latch_o     <= 1'b0;
                            erase_suspended_flag_o   <= 1'b1;
                            write_in_progress_flag_o <= 1'b0;
                        end
                    end
                    ST_SPROG: begin
                        if (pcnt_reg > 32'h00000001) begin
                            pcnt_reg <= pcnt_reg - 32'h00000001;
                        end else begin
                            state_reg                <= ST_SUSP;
                            write_in_progress_flag_o <= 1'b0;
                            write_enable_latch_o     <= 1'b0;
                        end
                    end
                    default: ;
                endcase
            end
        end
    end

    // ****************************************
    // Status word
    // ****************************************
    always @(posedge clk_sys_i or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            status_o <= 16'h0000;
        end else begin
            status_o                   <= 16'h0000;
            status_o[`SFSR_ST_WIP_BIT] <= write_in_progress_flag_o;
            status_o[`SFSR_ST_WEL_BIT] <= write_enable_latch_o;
            status_o[`SFSR_ST_SUS_BIT] <= erase_suspended_flag_o;
        end
    end
endmodule // sfsr_top

// ### sfsr_host.sv
`timescale 1ns/1ns
// ****************
// Host model
// ****************
module sfsr_host (
    // Clock
    input  wire       clk_sys_i,
    // Link
    input  wire       so_i,
    output reg        cs_n_o = 1'b1,
    output reg        sclk_o = 1'b0,
    output reg        si_o   = 1'b0,
    output reg  [7:0] rx_o   = 8'h00
);
    // Mode 0 frame, MSB first, clock still outside frames
    task send(input [31:0] w, input integer nb);
        integer i;
        begin
            @(negedge clk_sys_i);
            cs_n_o = 1'b0;
            for (i = 0; i < nb * 8; i = i + 1) begin
                si_o = w[31 - i];
                repeat (10) @(negedge clk_sys_i);
                sclk_o = 1'b1;
                rx_o = {rx_o[6:0], so_i};
                repeat (10) @(negedge clk_sys_i);
                sclk_o = 1'b0;
            end
            repeat (10) @(negedge clk_sys_i);
            cs_n_o = 1'b1;
            si_o = ~si_o;
            repeat (12) @(negedge clk_sys_i);
        end
    endtask
endmodule // sfsr_host

// ### sfsr_top_asserts.sv
`timescale 1ns/1ns
// ****************
// Checker
// ****************
module sfsr_top_asserts (
    // Clock and reset
    input wire        clk_sys_i,
    input wire        reset_n_i,
    // Link
    input wire        cs_n_i,
    input wire        sclk_i,
    input wire        si_i,
    input wire        so_o,
    input wire        so_oe_o,
    // Status and events
    input wire [15:0] status_o,
    input wire        erase_suspended_flag_o,
    input wire        write_in_progress_flag_o,
    input wire        write_enable_latch_o,
    input wire        cmd_accept_o,
    input wire        cmd_reject_o,
    input wire [7:0]  cmd_code_o,
    input wire        region_blocked_o,
    input wire        erase_done_o
);
    wire       erase_suspended_flag = erase_suspended_flag_o;
    wire       write_in_progress_flag = write_in_progress_flag_o;
    wire       write_enable_latch = write_enable_latch_o;
    wire       ev  = cmd_accept_o | cmd_reject_o;
    wire [7:0] c   = cmd_code_o;
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (!reset_n_i);
    a_entry_clears_wel: assert property ($rose(erase_suspended_flag) |-> !write_enable_latch && !write_in_progress_flag)
        else $error("bad suspend entry");
    a_status_map: assert property (status_o == {$past(erase_suspended_flag), 13'h0, $past(write_enable_latch), $past(write_in_progress_flag)})
        else $error("bad status word");
    a_resume_fast: assert property ($rose(cs_n_i) && erase_suspended_flag && !write_in_progress_flag && c == 8'h7a |-> ##[1:25] (write_in_progress_flag && !erase_suspended_flag))
        else $error("slow resume");
    a_resume_gate: assert property ($rose(write_in_progress_flag) && c == 8'h7a |-> $past(erase_suspended_flag))
        else $error("resume without suspend");
    a_resume_clear: assert property ($fell(erase_suspended_flag) && c == 8'h7a |-> write_in_progress_flag)
        else $error("resume left busy low");
    a_early_set: assert property (ev && c inside {8'h05, 8'h35, 8'h15, 8'h66, 8'h99} |-> cmd_accept_o)
        else $error("early code refused");
    a_late_set: assert property (ev && erase_suspended_flag && !write_in_progress_flag && c inside {8'h06, 8'h04, 8'h03, 8'h0b, 8'h3b, 8'h6b, 8'hbb,
        8'heb, 8'he7, 8'h77, 8'h90, 8'h92, 8'h94, 8'h9f, 8'h4b, 8'hab, 8'h48, 8'h5a, 8'h02, 8'h32} |-> cmd_accept_o)
        else $error("late code refused");
    a_resume_ignored: assert property (ev && c == 8'h7a && !(erase_suspended_flag && !write_in_progress_flag) |-> cmd_reject_o)
        else $error("resume not ignored");
    a_reject_keeps: assert property (cmd_reject_o && erase_suspended_flag |=> erase_suspended_flag [*8])
        else $error("reject changed state");
    a_region_susp: assert property (region_blocked_o |-> erase_suspended_flag)
        else $error("block outside suspend");
    a_done_idle: assert property (erase_done_o |-> ##[0:2] !write_in_progress_flag)
        else $error("busy after erase");
endmodule // sfsr_top_asserts

bind sfsr_top sfsr_top_asserts i_sfsr_top_asserts (.clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i),
    .cs_n_i(cs_n_i), .sclk_i(sclk_i), .si_i(si_i), .so_o(so_o), .so_oe_o(so_oe_o), .status_o(status_o),
    .erase_suspended_flag_o(erase_suspended_flag_o), .write_in_progress_flag_o(write_in_progress_flag_o),
    .write_enable_latch_o(write_enable_latch_o), .cmd_accept_o(cmd_accept_o), .cmd_reject_o(cmd_reject_o),
    .cmd_code_o(cmd_code_o), .region_blocked_o(region_blocked_o), .erase_done_o(erase_done_o));

// ### sfsr_top_test.sv
`timescale 1ns/1ns
`include "sfsr_map.vh"
// ****************
// Bench
// ****************
module sfsr_top_test;
    localparam [159:0] LATE = {64'h0604030b3b6bbbeb, 64'he77790929f4bab48, 32'h5a029432};
    reg         clk_sys_i = 1'b0;
    reg         reset_n_i = 1'b0;
    reg         got_acc   = 1'b0;
    reg         got_rej   = 1'b0;
    reg         got_blk   = 1'b0;
    wire        cs_n, sclk, si, so, so_oe, erase_suspended_flag, write_in_progress_flag, write_enable_latch, acc, rej, blk, done;
    wire [15:0] st;
    wire [7:0]  code;
    wire [7:0]  rx;
    integer     miscompares = 0;
    integer     n_compared  = 0;
    integer     k;
    always #4 clk_sys_i = ~clk_sys_i;
    always @(posedge clk_sys_i) begin
        if (acc) got_acc <= 1'b1;
        if (rej) got_rej <= 1'b1;
        if (blk) got_blk <= 1'b1;
    end
    sfsr_host i_sfsr_host (.clk_sys_i(clk_sys_i), .so_i(so), .cs_n_o(cs_n), .sclk_o(sclk), .si_o(si), .rx_o(rx));
    sfsr_top #(.ERASE_CYCLES(32'd4000), .PROG_CYCLES(32'd50), .WRSR_CYCLES(32'd1500), .SUSP_LAT_CYCLES(32'd900))
        i_sfsr_top (.clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i), .cs_n_i(cs_n), .sclk_i(sclk), .si_i(si),
        .so_o(so), .so_oe_o(so_oe), .status_o(st), .erase_suspended_flag_o(erase_suspended_flag), .write_in_progress_flag_o(write_in_progress_flag),
        .write_enable_latch_o(write_enable_latch), .cmd_accept_o(acc), .cmd_reject_o(rej), .cmd_code_o(code),
        .region_blocked_o(blk), .erase_done_o(done));
    task chk(input [31:0] got, input [31:0] exp);
        begin
            n_compared = n_compared + 1;
            if (got !== exp) begin
                miscompares = miscompares + 1;
                $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
            end
        end
    endtask
    task cmd(input [31:0] w, input integer nb);
        begin
            got_acc = 1'b0;
            got_rej = 1'b0;
            got_blk = 1'b0;
            i_sfsr_host.send(w, nb);
        end
    endtask
    task give_verdict;
        begin
            $display("compared=%0d miscompares=%0d", n_compared, miscompares);
            if (miscompares == 0 && n_compared > 0) $display("DONE - PASS");
            else $display("DONE - FAIL");
            $finish;
        end
    endtask
    task t_erase_suspend;
        begin
            cmd({`SFSR_OP_WREN, 24'h0}, 1);
            cmd({`SFSR_OP_SE, 24'h123456}, 4);
            chk(write_in_progress_flag, 1'b1);
            cmd({`SFSR_OP_SUSP, 24'h0}, 1);
            cmd({`SFSR_OP_RDSR1, 24'h0}, 2);
            chk({got_acc, rx[0]}, 2'b11);
            cmd({`SFSR_OP_RSTEN, 24'h0}, 1);
            chk(got_acc, 1'b1);
            cmd({`SFSR_OP_FRD, 24'h0}, 1);
            chk({got_rej, erase_suspended_flag}, 2'b10);
            for (k = 0; k < 1000 && erase_suspended_flag !== 1'b1; k = k + 1) @(negedge clk_sys_i);
            chk({erase_suspended_flag, write_enable_latch, write_in_progress_flag}, 3'b100);
            cmd({`SFSR_OP_RDSR2, 24'h0}, 2);
            chk(rx[7], 1'b1);
        end
    endtask
    task t_suspended_sets;
        begin
            for (k = 0; k < 20; k = k + 1) begin
                cmd({LATE[159 - 8 * k -: 8], 24'h0}, 1);
                chk(got_acc, 1'b1);
            end
            cmd({`SFSR_OP_BE64, 24'h0}, 1);
            chk({got_rej, erase_suspended_flag}, 2'b11);
            cmd({`SFSR_OP_RD, 24'h123fff}, 4);
            chk(got_blk, 1'b1);
            cmd({`SFSR_OP_RD, 24'h124000}, 4);
            chk(got_blk, 1'b0);
        end
    endtask
    task t_resume;
        begin
            cmd({`SFSR_OP_RESUME, 24'h0}, 1);
            chk({erase_suspended_flag, write_in_progress_flag}, 2'b01);
            for (k = 0; k < 6000 && done !== 1'b1; k = k + 1) @(negedge clk_sys_i);
            repeat (4) @(negedge clk_sys_i);
            chk({k < 6000, write_in_progress_flag}, 2'b10);
            cmd({`SFSR_OP_RESUME, 24'h0}, 1);
            chk({got_rej, write_in_progress_flag}, 2'b10);
        end
    endtask
    task t_wrsr;
        begin
            cmd({`SFSR_OP_WREN, 24'h0}, 1);
            cmd({`SFSR_OP_WRSR, 24'h0}, 2);
            cmd({`SFSR_OP_SUSP, 24'h0}, 1);
            for (k = 0; k < 3000 && write_in_progress_flag !== 1'b0; k = k + 1) @(negedge clk_sys_i);
            chk({erase_suspended_flag, write_in_progress_flag}, 2'b00);
        end
    endtask
    initial begin
        repeat (8) @(negedge clk_sys_i);
        reset_n_i = 1'b1;
        repeat (4) @(negedge clk_sys_i);
        t_erase_suspend;
        t_suspended_sets;
        t_resume;
        t_wrsr;
        give_verdict;
    end
    initial begin
        #300000;
        miscompares = miscompares + 1;
        give_verdict;
    end
endmodule // sfsr_top_test
